// ### include/cise_pkg.sv
package cise_pkg;

    // ==========================================================
    // widths
    // ==========================================================
    localparam int PC_W        = 13;
    localparam int INSTR_W     = 14;
    localparam int FILE_W      = 7;
    localparam int DATA_W      = 8;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W        = 3;

    // ==========================================================
    // instruction fields
    // ==========================================================
    localparam int FILE_LSB    = 0;
    localparam int DEST_POS    = 7;
    localparam int BIT_LSB     = 7;
    localparam int BIT_W       = 3;
    localparam int CALL_K_W    = 11;
    localparam int LATCH_LSB   = 3;
    localparam int LATCH_W     = 2;

    // ==========================================================
    // opcode masks and match values
    // ==========================================================
    localparam logic [13:0] BTS_MASK   = 14'h3C00;
    localparam logic [13:0] BTS_MATCH  = 14'h1C00;
    localparam logic [13:0] CALL_MASK  = 14'h3800;
    localparam logic [13:0] CALL_MATCH = 14'h2000;
    localparam logic [13:0] CLR_MASK   = 14'h3F80;
    localparam logic [13:0] CLR_MATCH  = 14'h0180;
    localparam logic [13:0] MOV_MASK   = 14'h3F00;
    localparam logic [13:0] MOV_MATCH  = 14'h0800;
    localparam logic [13:0] STW_MASK   = 14'h3F80;
    localparam logic [13:0] STW_MATCH  = 14'h0080;
    localparam logic [13:0] OPT_MASK   = 14'h3FFF;
    localparam logic [13:0] OPT_MATCH  = 14'h0062;
    localparam logic [13:0] NOP_MASK   = 14'h3F9F;
    localparam logic [13:0] NOP_MATCH  = 14'h0000;

    // ==========================================================
    // reset values, pc step, interrupt vector and clear value
    // ==========================================================
    localparam logic [12:0] PC_RESET     = 13'h0000;
    localparam logic [12:0] PC_STEP      = 13'h0001;
    localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
    localparam logic [7:0]  W_RESET      = 8'h00;
    localparam logic [7:0]  OPTION_RESET = 8'hFF;
    localparam logic [7:0]  CLEAR_VALUE  = 8'h00;
    localparam logic [13:0] INSTR_RESET  = 14'h0000;

endpackage

// ### rtl/cise_stack.sv
module cise_stack
    import cise_pkg::*;
(
    input  wire logic                  clock_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  push_i,
    input  wire logic [cise_pkg::PC_W-1:0] data_i,
    output logic      [cise_pkg::PC_W-1:0] top_o
);

    // ==========================================================
    // circular return stack, push only from this core slice
    // ==========================================================
    // overflow wraps and overwrites the oldest entry, no error flag
    logic [PC_W-1:0] mem_reg [STACK_DEPTH];
    logic [SP_W-1:0] sp_reg;
    logic [SP_W-1:0] sp_next;
    logic [PC_W-1:0] top_reg;
    logic [PC_W-1:0] top_next;

    // next pointer and visible top
    always_comb
    begin
        sp_next  = sp_reg;
        top_next = top_reg;
        if (push_i)
        begin
            sp_next  = sp_reg + SP_W'(1);
            top_next = data_i;
        end
    end

    // entries are data only, left without reset
    always_ff @(posedge clock_i)
    begin
        if (push_i)
        begin
            mem_reg[sp_next] <= data_i;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sp_reg  <= '0;
            top_reg <= PC_RESET;
        end
        else
        begin
            sp_reg  <= sp_next;
            top_reg <= top_next;
        end
    end

    assign top_o = top_reg;

endmodule

// ### rtl/cise_core.sv
// What this block does
// - interrupt entry pushes only return address; w and flags stay untouched
// - bit test skip decodes 01 11bb bfff ffff, skips next if bit set
// - taken skip discards fetched instruction as nop, two cycles, no flags
// - call decodes 10 0kkk kkkk kkkk, 11-bit target, flags unchanged
// - call pushes pc+1, pc gets latch bits 4:3 and k, two cycles
// - clear decodes 00 0001 1fff ffff, writes 00h, sets zero, one cycle
// - move decodes 00 1000 dfff ffff, to w or back, updates zero
// - store working decodes 00 0000 1fff ffff, writes w, no flags
// - option load 0062h copies w into option, one cycle, no flags
module cise_core
    import cise_pkg::*;
(
    input  wire logic                        clock_i,
    input  wire logic                        reset_n_i,
    input  wire logic [cise_pkg::INSTR_W-1:0] instr_i,
    input  wire logic                        irq_enter_i,
    input  wire logic [cise_pkg::DATA_W-1:0] pc_high_latch_i,
    input  wire logic [cise_pkg::DATA_W-1:0] rf_rdata_i,
    output logic      [cise_pkg::PC_W-1:0]   pc_o,
    output logic      [cise_pkg::FILE_W-1:0] rf_raddr_o,
    output logic      [cise_pkg::FILE_W-1:0] rf_waddr_o,
    output logic      [cise_pkg::DATA_W-1:0] rf_wdata_o,
    output logic                             rf_we_o,
    output logic      [cise_pkg::DATA_W-1:0] w_o,
    output logic                             zero_o,
    output logic                             zero_we_o,
    output logic      [cise_pkg::DATA_W-1:0] option_o,
    output logic      [cise_pkg::PC_W-1:0]   stack_top_o,
    output logic                             unsupported_o
);

    // ==========================================================
    // state
    // ==========================================================
    logic [PC_W-1:0]    pc_reg, pc_next;
    logic [INSTR_W-1:0] ir_reg, ir_next;
    logic               ex_valid_reg, ex_valid_next;
    logic               discard_reg, discard_next;
    logic               irq_pend_reg, irq_pend_next;
    logic [DATA_W-1:0]  w_reg, w_next;
    logic               zero_reg, zero_next;
    logic               zero_we_reg, zero_we_next;
    logic [DATA_W-1:0]  option_reg, option_next;
    logic               we_reg, we_next;
    logic [FILE_W-1:0]  waddr_reg, waddr_next;
    logic [DATA_W-1:0]  wdata_reg, wdata_next;
    logic               unsup_reg, unsup_next;

    // ==========================================================
    // decode of the executing instruction
    // ==========================================================
    logic              exec;
    logic              is_bts, is_call, is_clr, is_mov, is_stw;
    logic              is_opt, is_nop;
    logic [FILE_W-1:0] f_addr;
    logic [BIT_W-1:0]  bit_sel;
    logic [DATA_W-1:0] f_data;
    logic              skip_taken;
    logic              take_irq;
    logic              push;
    logic [PC_W-1:0]   push_data;

    // a discarded slot still occupies a cycle but executes as nop
    assign exec    = ex_valid_reg && !discard_reg;
    assign is_bts  = exec && ((ir_reg & BTS_MASK) == BTS_MATCH);
    assign is_call = exec && ((ir_reg & CALL_MASK) == CALL_MATCH);
    assign is_clr  = exec && ((ir_reg & CLR_MASK) == CLR_MATCH);
    assign is_mov  = exec && ((ir_reg & MOV_MASK) == MOV_MATCH);
    assign is_stw  = exec && ((ir_reg & STW_MASK) == STW_MATCH);
    assign is_opt  = exec && ((ir_reg & OPT_MASK) == OPT_MATCH);
    assign is_nop  = exec && ((ir_reg & NOP_MASK) == NOP_MATCH);
    assign f_addr  = ir_reg[FILE_LSB +: FILE_W];
    assign bit_sel = ir_reg[BIT_LSB +: BIT_W];

    // forward the pending write so back-to-back access sees fresh data
    assign f_data = (we_reg && waddr_reg == f_addr) ? wdata_reg : rf_rdata_i;
    assign skip_taken = is_bts && f_data[bit_sel];

    // entry waits while a branch already owns the next fetch slot
    assign take_irq = irq_pend_reg && ex_valid_reg && !discard_reg
                      && !is_call && !skip_taken;
    assign push      = is_call || take_irq;
    // the fetch address is the return address in both cases
    assign push_data = pc_reg;

    // ==========================================================
    // next state
    // ==========================================================
    always_comb
    begin
        pc_next       = pc_reg + PC_STEP;
        ir_next       = instr_i;
        ex_valid_next = 1'b1;
        discard_next  = 1'b0;
        irq_pend_next = (irq_pend_reg && !take_irq) || irq_enter_i;
        w_next        = w_reg;
        zero_next     = zero_reg;
        zero_we_next  = 1'b0;
        option_next   = option_reg;
        we_next       = 1'b0;
        waddr_next    = f_addr;
        wdata_next    = wdata_reg;
        unsup_next    = 1'b0;
        if (is_call)
        begin
            // upper pc bits come from the high latch
            pc_next = {pc_high_latch_i[LATCH_LSB +: LATCH_W],
                       ir_reg[CALL_K_W-1:0]};
            discard_next = 1'b1;
        end
        else if (skip_taken)
        begin
            discard_next = 1'b1;
        end
        if (take_irq)
        begin
            // only the pc is saved; w and zero are left alone
            pc_next      = IRQ_VECTOR;
            discard_next = 1'b1;
        end
        if (is_clr)
        begin
            we_next      = 1'b1;
            wdata_next   = CLEAR_VALUE;
            zero_next    = 1'b1;
            zero_we_next = 1'b1;
        end
        if (is_mov)
        begin
            zero_next    = (f_data == CLEAR_VALUE);
            zero_we_next = 1'b1;
            if (ir_reg[DEST_POS])
            begin
                we_next    = 1'b1;
                wdata_next = f_data;
            end
            else
            begin
                w_next = f_data;
            end
        end
        if (is_stw)
        begin
            we_next    = 1'b1;
            wdata_next = w_reg;
        end
        if (is_opt)
        begin
            option_next = w_reg;
        end
        unsup_next = exec && !(is_bts || is_call || is_clr || is_mov
                     || is_stw || is_opt || is_nop);
    end

    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pc_reg       <= PC_RESET;
            ir_reg       <= INSTR_RESET;
            ex_valid_reg <= 1'b0;
            discard_reg  <= 1'b0;
            irq_pend_reg <= 1'b0;
            w_reg        <= W_RESET;
            zero_reg     <= 1'b0;
            zero_we_reg  <= 1'b0;
            option_reg   <= OPTION_RESET;
            we_reg       <= 1'b0;
            waddr_reg    <= '0;
            wdata_reg    <= CLEAR_VALUE;
            unsup_reg    <= 1'b0;
        end
        else
        begin
            pc_reg       <= pc_next;
            ir_reg       <= ir_next;
            ex_valid_reg <= ex_valid_next;
            discard_reg  <= discard_next;
            irq_pend_reg <= irq_pend_next;
            w_reg        <= w_next;
            zero_reg     <= zero_next;
            zero_we_reg  <= zero_we_next;
            option_reg   <= option_next;
            we_reg       <= we_next;
            waddr_reg    <= waddr_next;
            wdata_reg    <= wdata_next;
            unsup_reg    <= unsup_next;
        end
    end

    // return address stack
    cise_stack u_stack
    (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .push_i    (push),
        .data_i    (push_data),
        .top_o     (stack_top_o)
    );

    // outputs straight from flip-flops
    assign pc_o          = pc_reg;
    assign rf_raddr_o    = ir_reg[FILE_LSB +: FILE_W];
    assign rf_waddr_o    = waddr_reg;
    assign rf_wdata_o    = wdata_reg;
    assign rf_we_o       = we_reg;
    assign w_o           = w_reg;
    assign zero_o        = zero_reg;
    assign zero_we_o     = zero_we_reg;
    assign option_o      = option_reg;
    assign unsupported_o = unsup_reg;

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    property p_irq_pc_only;
        take_irq |=> pc_o == IRQ_VECTOR && stack_top_o == $past(pc_reg)
                     && ($past(is_mov && !ir_reg[DEST_POS]) || $stable(w_o))
                     && ($past(is_clr || is_mov) || $stable(zero_o));
    endproperty
    a_irq_pc_only: assert property (p_irq_pc_only)
        else $error("interrupt entry saved more than the pc");

    property p_skip_discard;
        skip_taken |=> discard_reg ##1 !discard_reg || take_irq;
    endproperty
    a_skip_discard: assert property (p_skip_discard)
        else $error("taken skip did not discard one slot");

    property p_discard_nop;
        ex_valid_reg && discard_reg |=> !rf_we_o && $stable(w_o)
                                       && !zero_we_o;
    endproperty
    a_discard_nop: assert property (p_discard_nop)
        else $error("discarded slot changed state");

    property p_call_target;
        is_call |=> pc_o == {$past(pc_high_latch_i[4:3]),
                             $past(ir_reg[10:0])}
                    && stack_top_o == $past(pc_reg) && !zero_we_o;
    endproperty
    a_call_target: assert property (p_call_target)
        else $error("call target or return address wrong");

    property p_call_two;
        is_call |=> discard_reg ##1 pc_o == $past(pc_o) + 13'h0001;
    endproperty
    a_call_two: assert property (p_call_two)
        else $error("call did not take two cycles");

    property p_clear;
        is_clr |=> rf_we_o && rf_wdata_o == 8'h00 && zero_o
                   && rf_waddr_o == $past(f_addr);
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not write zero and set flag");

    property p_move;
        is_mov |=> zero_o == ($past(f_data) == 8'h00)
                   && (rf_we_o ? rf_wdata_o : w_o) == $past(f_data)
                   && rf_we_o == $past(ir_reg[7]);
    endproperty
    a_move: assert property (p_move)
        else $error("move result or zero flag wrong");

    property p_store;
        is_stw |=> rf_we_o && rf_wdata_o == $past(w_o) && !zero_we_o;
    endproperty
    a_store: assert property (p_store)
        else $error("store working wrote wrong value");

    property p_option;
        is_opt |=> option_o == $past(w_o) && !rf_we_o && !zero_we_o;
    endproperty
    a_option: assert property (p_option)
        else $error("option load failed");

    property p_nop;
        is_nop && !take_irq |=> !rf_we_o && !zero_we_o && $stable(w_o)
                   && $stable(stack_top_o) && pc_o == $past(pc_o) + 13'h0001;
    endproperty
    a_nop: assert property (p_nop)
        else $error("nop changed state");

    c_call:  cover property (is_call);
    c_skip:  cover property (skip_taken);
    c_irq:   cover property (take_irq);
    c_clear: cover property (is_clr ##1 is_mov);

endmodule

// ### verification/cise_core_tb.sv
module cise_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cise_pkg::*;

    // ==========================================================
    // clock, ports and bench state
    // ==========================================================
    localparam int TIMEOUT_CYCLES = 2000;

    logic                 clock_i         = 1'b0;
    logic                 reset_n_i       = 1'b0;
    logic [INSTR_W-1:0]   instr_i         = 14'h0000;
    logic                 irq_enter_i     = 1'b0;
    logic [DATA_W-1:0]    pc_high_latch_i = 8'h00;
    logic [DATA_W-1:0]    rf_rdata_i      = 8'h00;
    logic [PC_W-1:0]      pc_o;
    logic [FILE_W-1:0]    rf_raddr_o;
    logic [FILE_W-1:0]    rf_waddr_o;
    logic [DATA_W-1:0]    rf_wdata_o;
    logic                 rf_we_o;
    logic [DATA_W-1:0]    w_o;
    logic                 zero_o;
    logic                 zero_we_o;
    logic [DATA_W-1:0]    option_o;
    logic [PC_W-1:0]      stack_top_o;
    logic                 unsupported_o;
    logic [INSTR_W-1:0]   prog [0:8191];
    logic [DATA_W-1:0]    rf   [0:127];
    int                   n_errors        = 0;
    int                   samples_checked = 0;
    int                   cycles          = 0;
    int                   n_zero_we       = 0;

    always #4 clock_i = ~clock_i;

    cise_core u_dut (
        .clock_i         (clock_i),
        .reset_n_i       (reset_n_i),
        .instr_i         (instr_i),
        .irq_enter_i     (irq_enter_i),
        .pc_high_latch_i (pc_high_latch_i),
        .rf_rdata_i      (rf_rdata_i),
        .pc_o            (pc_o),
        .rf_raddr_o      (rf_raddr_o),
        .rf_waddr_o      (rf_waddr_o),
        .rf_wdata_o      (rf_wdata_o),
        .rf_we_o         (rf_we_o),
        .w_o             (w_o),
        .zero_o          (zero_o),
        .zero_we_o       (zero_we_o),
        .option_o        (option_o),
        .stack_top_o     (stack_top_o),
        .unsupported_o   (unsupported_o)
    );

    // ==========================================================
    // memories around the core
    // ==========================================================
    // writes land on the edge after the strobe, as the external file would
    always @(posedge clock_i)
    begin
        cycles++;
        if (reset_n_i === 1'b1 && rf_we_o === 1'b1)
            rf[rf_waddr_o] = rf_wdata_o;
        if (zero_we_o === 1'b1)
            n_zero_we++;
        if (cycles == TIMEOUT_CYCLES)
        begin
            n_errors++;
            finish_test();
        end
    end

    // reads are driven on the falling edge, well clear of the sampling edge
    always @(negedge clock_i)
    begin
        instr_i    <= prog[pc_o];
        rf_rdata_i <= rf[rf_raddr_o];
    end

    // ==========================================================
    // shared tasks
    // ==========================================================
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
                           input string what);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp,
                           input string what);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: %s got %b expected %b",
                     $time, what, got, exp);
        end
    endtask

    // program memory is all no-ops and every file byte 11h unless set
    task automatic restart();
        @(negedge clock_i);
        reset_n_i   = 1'b0;
        irq_enter_i = 1'b0;
        for (int i = 0; i < 8192; i++)
            prog[i] = 14'h0000;
        for (int i = 0; i < 128; i++)
            rf[i] = 8'h11;
    endtask

    task automatic go();
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        reset_n_i = 1'b1;
    endtask

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clock_i);
            @(negedge clock_i);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    // ==========================================================
    // clear, move both ways, store, option load and no-op back to back
    task automatic test_file_ops();
        restart();
        rf[7'h20] = 8'h33;
        rf[7'h21] = 8'h5A;
        prog[0] = 14'h01A0;
        prog[1] = 14'h0821;
        prog[2] = 14'h00A2;
        prog[3] = 14'h0062;
        prog[4] = 14'h0060;
        prog[5] = 14'h08A0;
        go();
        tick(2);
        chk_bit(rf_we_o, 1'b1, "clear strobe");
        chk_val(16'(rf_waddr_o), 16'h0020, "clear addr");
        chk_val(16'(rf_wdata_o), 16'h0000, "clear data");
        chk_bit(zero_o, 1'b1, "clear zero");
        chk_val(16'(rf_raddr_o), 16'h0021, "move read addr");
        tick(1);
        chk_val(16'(w_o), 16'h005A, "move to w");
        chk_bit(zero_o, 1'b0, "move zero");
        chk_bit(rf_we_o, 1'b0, "move d0 strobe");
        tick(1);
        chk_bit(rf_we_o, 1'b1, "store strobe");
        chk_val(16'(rf_waddr_o), 16'h0022, "store addr");
        chk_val(16'(rf_wdata_o), 16'h005A, "store data");
        chk_bit(zero_we_o, 1'b0, "store flag");
        chk_val(16'(option_o), 16'(OPTION_RESET), "option idle");
        tick(1);
        chk_val(16'(option_o), 16'h005A, "option load");
        chk_bit(zero_we_o, 1'b0, "option flag");
        tick(1);
        chk_bit(rf_we_o, 1'b0, "nop strobe");
        chk_bit(zero_we_o, 1'b0, "nop flag");
        chk_val(16'(pc_o), 16'h0006, "nop pc");
        chk_val(16'(stack_top_o), 16'h0000, "nop stack");
        chk_bit(unsupported_o, 1'b0, "nop decode");
        tick(1);
        chk_val(16'(rf_waddr_o), 16'h0020, "move back addr");
        chk_val(16'(rf_wdata_o), 16'h0000, "move back data");
        chk_bit(zero_o, 1'b1, "move back zero");
    endtask

    // skip taken, not taken, and at the top bit and top address
    task automatic test_skip();
        int z0;
        restart();
        rf[7'h30] = 8'h08;
        rf[7'h7F] = 8'h80;
        prog[0] = 14'h1DB0;
        prog[1] = 14'h01B1;
        prog[2] = 14'h1D30;
        prog[3] = 14'h01B2;
        prog[4] = 14'h1FFF;
        prog[5] = 14'h01B3;
        go();
        z0 = n_zero_we;
        tick(10);
        chk_val(16'(rf[7'h31]), 16'h0011, "skipped slot");
        chk_val(16'(rf[7'h32]), 16'h0000, "not skipped");
        chk_val(16'(rf[7'h33]), 16'h0011, "skip top bit");
        chk_val(16'(n_zero_we - z0), 16'h0001, "skip flags");
        chk_val(16'(pc_o), 16'h000A, "skip pc");
    endtask

    // call with the widest target; only latch bits 4:3 may reach the pc
    task automatic test_call();
        restart();
        pc_high_latch_i = 8'hE8;
        prog[0] = 14'h01A0;
        prog[1] = 14'h27FF;
        prog[2] = 14'h01C0;
        prog[13'h0FFF] = 14'h01C1;
        prog[13'h1001] = 14'h3FFF;
        prog[13'h1003] = 14'h2100;
        prog[13'h0900] = 14'h0823;
        rf[7'h23]      = 8'h3C;
        go();
        tick(3);
        chk_val(16'(pc_o), 16'h0FFF, "call target");
        chk_val(16'(stack_top_o), 16'h0002, "call return");
        chk_bit(zero_o, 1'b1, "call zero");
        chk_bit(zero_we_o, 1'b0, "call flag");
        tick(1);
        chk_bit(rf_we_o, 1'b0, "call slot");
        chk_val(16'(pc_o), 16'h1000, "call next");
        tick(1);
        chk_val(16'(rf_waddr_o), 16'h0041, "call body");
        tick(2);
        chk_bit(unsupported_o, 1'b1, "foreign opcode flag");
        chk_bit(rf_we_o, 1'b0, "foreign opcode strobe");
        // entry requested while a call executes must wait out its slot
        irq_enter_i = 1'b1;
        tick(1);
        irq_enter_i = 1'b0;
        tick(1);
        chk_val(16'(pc_o), 16'h0900, "irq held over call");
        chk_val(16'(stack_top_o), 16'h1004, "call under irq");
        tick(1);
        chk_val(16'(pc_o), 16'h0901, "irq held over slot");
        tick(1);
        chk_val(16'(pc_o), 16'(IRQ_VECTOR), "late irq vector");
        chk_val(16'(stack_top_o), 16'h0901, "late irq return");
        chk_val(16'(w_o), 16'h003C, "move beside irq");
        chk_bit(zero_o, 1'b0, "zero beside irq");
    endtask

    // interrupt entry saves only the return address
    task automatic test_irq();
        restart();
        rf[7'h21] = 8'h5A;
        prog[0] = 14'h0821;
        prog[1] = 14'h01D0;
        go();
        tick(8);
        irq_enter_i = 1'b1;
        tick(1);
        irq_enter_i = 1'b0;
        tick(1);
        chk_val(16'(pc_o), 16'(IRQ_VECTOR), "irq vector");
        chk_val(16'(stack_top_o), 16'h0009, "irq return");
        chk_val(16'(w_o), 16'h005A, "irq w");
        chk_bit(zero_o, 1'b1, "irq zero");
        chk_bit(rf_we_o, 1'b0, "irq no save");
        tick(1);
        chk_bit(rf_we_o, 1'b0, "irq no save");
    endtask

    // ==========================================================
    // main sequence
    // ==========================================================
    initial
    begin
        test_file_ops();
        test_skip();
        test_call();
        test_irq();
        finish_test();
    end
endmodule
